//--- core/pwsq_pkg.sv
package pwsq_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // times in ns
  localparam int unsigned DEGLITCH_NS  = 15000;
  localparam int unsigned SLOW_SHORT_NS = 1500000;
  localparam int unsigned SLOW_LONG_NS  = 10000000;
  localparam int unsigned FAST_ON_NS   = 3000;
  localparam int unsigned FAST_OFF_NS  = 2250;
  localparam int unsigned OV_FILT_NS   = 10000;
  localparam int unsigned CLK_NS       = 1000000000 / CLK_HZ;
  // least times round up, longest times round down
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOW_SHORT_CYC = SLOW_SHORT_NS / CLK_NS;
  localparam int unsigned SLOW_LONG_CYC  = SLOW_LONG_NS / CLK_NS;
  localparam int unsigned FAST_ON_CYC  = FAST_ON_NS / CLK_NS;
  localparam int unsigned FAST_OFF_CYC = FAST_OFF_NS / CLK_NS;
  localparam int unsigned OV_FILT_CYC  = (OV_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned NUM_GD = 4;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_GDEN   = 8'h04;
  localparam logic [7:0] REG_STATE  = 8'h08;
  localparam logic [7:0] REG_IRQ    = 8'h0C;
  localparam logic [7:0] REG_MASK   = 8'h10;
  // ctrl bits
  localparam int unsigned CTRL_SPEED = 0;
  localparam int unsigned CTRL_USEL  = 1;
  localparam int unsigned CTRL_S1    = 2;
  localparam int unsigned CTRL_S2    = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [4:0] MASK_RST = 5'h00;
  // irq bits
  localparam int unsigned IRQ_MRST = 0;
  localparam int unsigned IRQ_RUN  = 1;
  localparam int unsigned IRQ_OFF  = 2;
  localparam int unsigned IRQ_FF   = 3;
  localparam int unsigned IRQ_GD   = 4;
  localparam int unsigned IRQ_W    = 5;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_PRE   = 3'b001,
    ST_UC    = 3'b010,
    ST_GEN   = 3'b011,
    ST_RUN   = 3'b100,
    ST_DGL   = 3'b101,
    ST_SHDN  = 3'b110,
    ST_PREDN = 3'b111
  } pwsq_state_t;
endpackage

//--- core/pwsq_gate_delay.sv
`timescale 1ns/1ps
`default_nettype none
// one gate driver: applies a written command after a timed delay
module pwsq_gate_delay
  import pwsq_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // command
  input  wire logic             load_in,
  input  wire logic             cmd_in,
  input  wire logic [CNT_W-1:0] dly_in,
  input  wire logic             allow_in,
  // gate
  output logic                  gate_out,
  output logic                  done_out
);
  logic             pend_q, pend_d;
  logic             cmd_q, cmd_d;
  logic             gate_q, gate_d;
  logic             done_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    pend_d = pend_q;
    cmd_d  = cmd_q;
    gate_d = gate_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load_in) begin
      pend_d = 1'b1;
      cmd_d  = cmd_in;
      cnt_d  = dly_in;
    end else if (pend_q) begin
      if (cnt_q <= CNT_W'(1)) begin
        pend_d = 1'b0;
        gate_d = cmd_q;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
    if (!allow_in) begin
      gate_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      cmd_q  <= 1'b0;
      gate_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      pend_q <= pend_d;
      cmd_q  <= cmd_d;
      gate_q <= gate_d;
      cnt_q  <= cnt_d;
    end
  end

  // master reset or lost permission drops the gate at once
  assign gate_out = gate_q && allow_in;
  assign done_out = done_d;

  // delay ends exactly at the expiry
  a_gate_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    done_d && allow_in |=> gate_q == $past(cmd_q)) else $error("gate missed command");
endmodule
`default_nettype wire

//--- core/pwsq_filter.sv
`timescale 1ns/1ps
`default_nettype none
// holds a condition until it persists for a set count
module pwsq_filter
  import pwsq_pkg::*;
#(
  parameter int unsigned COUNT = 1
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // condition
  input  wire logic raw_in,
  output logic      hit_out
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             hit_q, hit_d;

  always_comb begin
    cnt_d = cnt_q;
    hit_d = 1'b0;
    if (!raw_in) begin
      cnt_d = '0;
    end else if (cnt_q >= CNT_W'(COUNT)) begin
      hit_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  assign hit_out = hit_q;
endmodule
`default_nettype wire

//--- core/pwsq_top.sv
// What this block does
// - Either enable input high forms the run request.
// - Any supply, bandgap, thermal, diode or current-limit fault asserts master reset, all off.
// - Startup turns on pre-regulator, then micro rail, then 5 V rail; host reset rises on micro good.
// - Sensor rails and gate drivers follow requests only after the 5 V rail is good.
// - Both enables low: 15 us deglitch, drop host reset, rails off in reverse order.
// - Host reset goes low as the deglitch ends, on entry to shutdown, in the same cycle as the 5 V rail turns off.
// - A missing catch diode latches master reset until an enable or supply cycle.
// - Switch-node overcurrent latches master reset until an enable or supply cycle.
// - Persistent charge-pump overvoltage drives fault flag low, unlatched, rails stay on.
// - Slow setting: battery isolator gate switches 1.5 ms after its command.
// - Slow setting: phase U switches 1.5 ms with select 1, 10 ms with select 0.
// - Slow setting: phases V and W switch 10 ms after command.
// - Fast setting: gates switch within 3 us on and 2.25 us off.
`timescale 1ns/1ps
`default_nettype none
module pwsq_top
  import pwsq_pkg::*;
(
  // clock and reset (rst_in is the supply power-up reset)
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // enables
  input  wire logic        logic_enable_input_in,
  input  wire logic        ignition_enable_input_in,
  // fault detectors
  input  wire logic        core_supply_undervoltage_in,
  input  wire logic        charge_pump_undervoltage_in,
  input  wire logic        first_bandgap_undervoltage_in,
  input  wire logic        second_bandgap_undervoltage_in,
  input  wire logic        thermal_shutdown_flag_in,
  input  wire logic        catch_diode_missing_in,
  input  wire logic        switch_node_overcurrent_in,
  input  wire logic        first_charge_pump_overvoltage_in,
  // rail undervoltage flags
  input  wire logic        pre_regulator_uv_in,
  input  wire logic        micro_rail_uv_in,
  input  wire logic        general_5v_rail_uv_in,
  input  wire logic        sensor_rails_uv_in,
  // rail enables
  output logic             pre_regulator_output_en_out,
  output logic             micro_rail_en_out,
  output logic             general_5v_rail_en_out,
  output logic             sensor_rail_one_en_out,
  output logic             sensor_rail_two_en_out,
  // gate drivers: isolator, u, v, w
  output logic             battery_isolator_gate_out,
  output logic             phase_u_gate_out,
  output logic             phase_v_gate_out,
  output logic             phase_w_gate_out,
  // status pins
  output logic             master_internal_reset_out,
  output logic             host_reset_output_out,
  output logic             fault_flag_output_n_out,
  output logic             irq_out,
  // axi4-lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  pwsq_state_t        st_q, st_d;
  logic [CNT_W-1:0]   dg_q, dg_d;
  logic               latch_q, latch_d;
  logic               hrst_q, hrst_d;
  logic               run_q, run_d;
  logic [3:0]         ctrl_q, ctrl_d;
  logic [3:0]         gden_q, gden_d;
  logic [IRQ_W-1:0]   irq_q, irq_d, mask_q, mask_d, ev;
  logic               aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]         awa_q, awa_d;
  logic [31:0]        wd_q, wd_d, rd_q, rd_d;
  logic [1:0]         br_q, br_d, rr_q, rr_d;
  logic               run_req, mrst, allow, ov_hit, wr_fire, rd_fire, gd_load;
  logic [NUM_GD-1:0]  gates, gdone;
  logic [CNT_W-1:0]   dly [NUM_GD];

  assign run_req = logic_enable_input_in | ignition_enable_input_in;
  assign mrst = core_supply_undervoltage_in | charge_pump_undervoltage_in |
                first_bandgap_undervoltage_in | second_bandgap_undervoltage_in |
                thermal_shutdown_flag_in | latch_q;

  pwsq_filter #(.COUNT(OV_FILT_CYC)) u_ovf (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .raw_in  (first_charge_pump_overvoltage_in),
    .hit_out (ov_hit)
  );

  // sequencer
  always_comb begin
    st_d    = st_q;
    dg_d    = '0;
    hrst_d  = hrst_q;
    latch_d = latch_q;
    if (catch_diode_missing_in | switch_node_overcurrent_in) begin
      latch_d = 1'b1;
    end else if (!run_req) begin
      latch_d = 1'b0;
    end
    unique case (st_q)
      ST_OFF:   if (run_req) st_d = ST_PRE;
      ST_PRE:   if (!pre_regulator_uv_in) st_d = ST_UC;
      ST_UC:    if (!micro_rail_uv_in) begin
        st_d   = ST_GEN;
        hrst_d = 1'b1;
      end
      ST_GEN:   if (!general_5v_rail_uv_in) st_d = ST_RUN;
      ST_RUN:   if (!run_req) st_d = ST_DGL;
      ST_DGL: begin
        if (run_req) begin
          st_d = ST_RUN;
        end else if (dg_q >= CNT_W'(DEGLITCH_CYC - 1)) begin
          st_d   = ST_SHDN;
          hrst_d = 1'b0;
        end else begin
          dg_d = dg_q + CNT_W'(1);
        end
      end
      ST_SHDN: begin
        if (micro_rail_uv_in) hrst_d = 1'b0;
        if (general_5v_rail_uv_in) st_d = ST_PREDN;
      end
      ST_PREDN: if (micro_rail_uv_in) st_d = ST_OFF;
    endcase
    if (mrst) begin
      st_d   = ST_OFF;
      hrst_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q    <= ST_OFF;
      dg_q    <= '0;
      hrst_q  <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      dg_q    <= dg_d;
      hrst_q  <= hrst_d;
      latch_q <= latch_d;
    end
  end

  assign allow = (st_q == ST_RUN || st_q == ST_DGL || st_q == ST_SHDN) && !mrst;
  assign run_d = st_q == ST_RUN && !sensor_rails_uv_in;
  assign pre_regulator_output_en_out = st_q != ST_OFF && !mrst;
  assign micro_rail_en_out = (st_q != ST_OFF && st_q != ST_PRE && st_q != ST_PREDN) && !mrst;
  assign general_5v_rail_en_out = (st_q == ST_GEN || st_q == ST_RUN || st_q == ST_DGL) && !mrst;
  assign sensor_rail_one_en_out = allow && st_q != ST_SHDN && ctrl_q[CTRL_S1];
  assign sensor_rail_two_en_out = allow && st_q != ST_SHDN && ctrl_q[CTRL_S2];
  assign master_internal_reset_out = mrst;
  assign host_reset_output_out = hrst_q;
  assign fault_flag_output_n_out = !ov_hit;

  // gate drivers
  // delay select
  always_comb begin
    for (int i = 0; i < NUM_GD; i++) begin
      if (ctrl_q[CTRL_SPEED]) begin
        dly[i] = gden_d[i] ? CNT_W'(FAST_ON_CYC) : CNT_W'(FAST_OFF_CYC);
      end else if (i == 0 || (i == 1 && ctrl_q[CTRL_USEL])) begin
        dly[i] = CNT_W'(SLOW_SHORT_CYC);
      end else begin
        dly[i] = CNT_W'(SLOW_LONG_CYC);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GD; g++) begin : gen_gd
      pwsq_gate_delay u_gd (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .load_in  (gd_load && gden_d[g] != gden_q[g]),
        .cmd_in   (gden_d[g]),
        .dly_in   (dly[g]),
        .allow_in (allow),
        .gate_out (gates[g]),
        .done_out (gdone[g])
      );
    end
  endgenerate
  assign battery_isolator_gate_out = gates[0];
  assign phase_u_gate_out = gates[1];
  assign phase_v_gate_out = gates[2];
  assign phase_w_gate_out = gates[3];

  // axi4-lite slave
  assign wr_fire = aw_q && w_q && !bv_q;
  assign rd_fire = s_axi_arvalid && !rv_q;
  assign gd_load = wr_fire && awa_q == REG_GDEN;
  assign ev = {|gdone, ov_hit, st_d == ST_OFF && st_q != ST_OFF,
               run_d && !run_q, mrst};

  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
    ctrl_d = ctrl_q; gden_d = gden_q; mask_d = mask_q;
    irq_d = irq_q;
    if (s_axi_awvalid && !aw_q) begin aw_d = 1'b1; awa_d = s_axi_awaddr; end
    if (s_axi_wvalid && !w_q) begin w_d = 1'b1; wd_d = s_axi_wdata; end
    if (wr_fire) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = 2'b00;
      unique case (awa_q)
        REG_CTRL: ctrl_d = wd_q[3:0];
        REG_GDEN: gden_d = wd_q[3:0];
        REG_MASK: mask_d = wd_q[IRQ_W-1:0];
        REG_STATE, REG_IRQ: ;
        default:  br_d = 2'b10;
      endcase
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (rd_fire) begin
      rv_d = 1'b1; rr_d = 2'b00; rd_d = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CTRL:  rd_d[3:0] = ctrl_q;
        REG_GDEN:  rd_d[3:0] = gden_q;
        REG_STATE: rd_d[7:0] = {ov_hit, latch_q, hrst_q, run_q, 1'b0, st_q};
        REG_IRQ: begin
          rd_d[IRQ_W-1:0] = irq_q;
          irq_d = '0;
        end
        REG_MASK:  rd_d[IRQ_W-1:0] = mask_q;
        default:   rr_d = 2'b10;
      endcase
    end
    // set wins over read clear
    irq_d = irq_d | ev;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0000_0000;
      bv_q <= 1'b0; br_q <= 2'b00; rv_q <= 1'b0; rr_q <= 2'b00;
      rd_q <= 32'h0000_0000; ctrl_q <= CTRL_RST; gden_q <= 4'h0;
      mask_q <= MASK_RST; irq_q <= '0; run_q <= 1'b0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rr_q <= rr_d;
      rd_q <= rd_d; ctrl_q <= ctrl_d; gden_q <= gden_d;
      mask_q <= mask_d; irq_q <= irq_d; run_q <= run_d;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign irq_out = |(irq_q & mask_q);

  // assertions
  a_mrst_off: assert property (@(posedge clk_in) disable iff (rst_in)
    mrst |-> !micro_rail_en_out && !battery_isolator_gate_out) else $error("rails on in reset");
  a_or_start: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == ST_OFF && run_req && !mrst |=> st_q == ST_PRE) else $error("no start");
  a_hrst_up: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == ST_UC && !micro_rail_uv_in && !mrst |=> hrst_q) else $error("host reset stuck");
  a_gate_allow: assert property (@(posedge clk_in) disable iff (rst_in)
    !allow |=> !phase_v_gate_out) else $error("gate before 5 V");
  a_deglitch: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == ST_RUN ##1 (st_q == ST_DGL && !run_req && !mrst)[*8] |-> hrst_q) else $error("early drop");
  a_hrst_shdn: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == ST_SHDN |-> !hrst_q) else $error("host reset high in shutdown");
  a_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    latch_q && run_req |=> latch_q) else $error("latch lost");
  a_latch_set: assert property (@(posedge clk_in) disable iff (rst_in)
    switch_node_overcurrent_in |=> master_internal_reset_out) else $error("no latch");
  a_flag_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (!first_charge_pump_overvoltage_in |=> fault_flag_output_n_out) and
    (ov_hit |-> !fault_flag_output_n_out && !$fell(pre_regulator_output_en_out && !mrst)))
    else $error("flag");
  c_run: cover property (@(posedge clk_in) st_q == ST_RUN);
  c_shdn: cover property (@(posedge clk_in) st_q == ST_PREDN ##1 st_q == ST_OFF);
  c_latch: cover property (@(posedge clk_in) latch_q);
endmodule
`default_nettype wire

//--- bench/pwsq_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog rails: a flag clears once its rail has been enabled long enough
module pwsq_rail_model #(
  parameter int RISE = 5
)(
  // clock and ramp speed
  input  wire logic       clk_in,
  input  wire logic       slow_in,
  // rail enables and flags
  input  wire logic [3:0] en_in,
  output logic      [3:0] uv_out
);
  int cnt [4] = '{0, 0, 0, 0};
  int lim;
  assign lim = slow_in ? 4 * RISE : RISE;
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (en_in[i] !== 1'h1) begin
        cnt[i] <= 0;
      end else if (cnt[i] < lim) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      uv_out[i] = cnt[i] < lim;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pwsq_pkg::*;
;
  typedef struct packed {
    logic le; logic ie; logic [6:0] flt; logic mr; logic lat;
  } pwsq_row_t;
  localparam int PRE = 0, UC = 1, GEN = 2, S1 = 3, GBB = 5, PHU = 6, GW = 8;
  localparam int HR = 10, FF = 11;
  logic        clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        le = 1'h0, ie = 1'h0, ov = 1'h0, slow = 1'h0;
  logic [6:0]  flt = 7'h00;
  logic [3:0]  uv;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        pre_en, uc_en, gen_en, s1_en, s2_en, g_bb, g_u, g_v, g_w;
  logic        mrst, hrst, fault_flag_output, irq;
  logic [12:0] mon;
  int          failures = 0, samples_checked = 0, n;
  pwsq_row_t   rows [10] = '{
    '{1'h1, 1'h0, 7'h00, 1'h0, 1'h0}, '{1'h0, 1'h1, 7'h00, 1'h0, 1'h0},
    '{1'h1, 1'h1, 7'h00, 1'h0, 1'h0}, '{1'h1, 1'h0, 7'h40, 1'h1, 1'h0},
    '{1'h1, 1'h0, 7'h20, 1'h1, 1'h0}, '{1'h1, 1'h0, 7'h10, 1'h1, 1'h0},
    '{1'h1, 1'h0, 7'h08, 1'h1, 1'h0}, '{1'h1, 1'h0, 7'h04, 1'h1, 1'h0},
    '{1'h1, 1'h0, 7'h02, 1'h1, 1'h1}, '{1'h1, 1'h0, 7'h01, 1'h1, 1'h1}};
  assign mon = {irq, fault_flag_output, hrst, mrst, g_w, g_v, g_u, g_bb, s2_en, s1_en, gen_en, uc_en, pre_en};
  always #20 clk_in = ~clk_in;
  pwsq_rail_model u_rails (.clk_in(clk_in), .slow_in(slow),
    .en_in({gen_en, gen_en, uc_en, pre_en}), .uv_out(uv));
  pwsq_top u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .logic_enable_input_in(le), .ignition_enable_input_in(ie),
    .core_supply_undervoltage_in(flt[6]), .charge_pump_undervoltage_in(flt[5]),
    .first_bandgap_undervoltage_in(flt[4]), .second_bandgap_undervoltage_in(flt[3]),
    .thermal_shutdown_flag_in(flt[2]), .catch_diode_missing_in(flt[1]),
    .switch_node_overcurrent_in(flt[0]), .first_charge_pump_overvoltage_in(ov),
    .pre_regulator_uv_in(uv[0]), .micro_rail_uv_in(uv[1]),
    .general_5v_rail_uv_in(uv[2]), .sensor_rails_uv_in(uv[3]),
    .pre_regulator_output_en_out(pre_en), .micro_rail_en_out(uc_en),
    .general_5v_rail_en_out(gen_en), .sensor_rail_one_en_out(s1_en),
    .sensor_rail_two_en_out(s2_en), .battery_isolator_gate_out(g_bb),
    .phase_u_gate_out(g_u), .phase_v_gate_out(g_v), .phase_w_gate_out(g_w),
    .master_internal_reset_out(mrst), .host_reset_output_out(hrst),
    .fault_flag_output_n_out(fault_flag_output), .irq_out(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic wait_on(input int i, input logic v, input int lim, output int k);
    k = 0;
    while (mon[i] !== v && k < lim) begin
      @(posedge clk_in);
      k++;
    end
    chk_bit(mon[i], v);
  endtask
  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    int k;
    @(posedge clk_in);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    rs = 2'h3;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        rs = bresp;
        bready <= 1'h0;
        break;
      end
    end
    chk_bit(k < 50, 1'h1);
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int k;
    @(posedge clk_in);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    rs = 2'h3;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        dt = rdata;
        rs = rresp;
        rready <= 1'h0;
        break;
      end
    end
    chk_bit(k < 50, 1'h1);
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    cyc(90000);
    failures++;
    wrap_up();
  end
  initial begin
    cyc(2);
    rst_in <= 1'h0;
    cyc(1);
    chk_bit(pre_en, 1'h0);
    chk_bit(hrst, 1'h0);
    chk_bit(fault_flag_output, 1'h1);
    chk_bit(mrst, 1'h0);
    axi_rd(REG_CTRL, d, r);
    chk_word(d, {28'h0, CTRL_RST});
    axi_rd(REG_MASK, d, r);
    chk_word(d, {27'h0, MASK_RST});
    $display("reset test done");
    foreach (rows[k]) begin
      le <= rows[k].le;
      ie <= rows[k].ie;
      flt <= rows[k].flt;
      cyc(60);
      chk_bit(mrst, rows[k].mr);
      chk_bit(pre_en, !rows[k].mr);
      chk_bit(hrst, !rows[k].mr);
      flt <= 7'h00;
      cyc(4);
      chk_bit(mrst, rows[k].lat);
      le <= 1'h0;
      ie <= 1'h0;
      cyc(DEGLITCH_CYC + 60);
      chk_bit(mrst, 1'h0);
      chk_bit(pre_en, 1'h0);
    end
    $display("row table done");
    slow <= 1'h1;
    axi_wr(REG_CTRL, 32'h0000000E, r);
    chk_word({30'h0, r}, 32'h0);
    le <= 1'h1;
    wait_on(PRE, 1'h1, 20, n);
    chk_bit(uc_en, 1'h0);
    wait_on(UC, 1'h1, 60, n);
    chk_bit(uv[0], 1'h0);
    chk_bit(s1_en, 1'h0);
    wait_on(HR, 1'h1, 60, n);
    chk_bit(uv[1], 1'h0);
    wait_on(S1, 1'h1, 100, n);
    chk_bit(uv[2], 1'h0);
    chk_bit(s2_en, 1'h1);
    axi_rd(REG_STATE, d, r);
    chk_word(d, 32'h00000034);
    $display("startup test done");
    axi_wr(REG_GDEN, 32'h00000007, r);
    wait_on(GBB, 1'h1, SLOW_SHORT_CYC + 8, n);
    chk_bit(n + 8 >= SLOW_SHORT_CYC, 1'h1);
    wait_on(PHU, 1'h1, 4, n);
    chk_bit(g_v, 1'h0);
    axi_wr(REG_CTRL, 32'h0000000F, r);
    axi_wr(REG_GDEN, 32'h00000000, r);
    wait_on(GBB, 1'h0, FAST_OFF_CYC + 4, n);
    axi_wr(REG_GDEN, 32'h0000000F, r);
    wait_on(GW, 1'h1, FAST_ON_CYC + 4, n);
    chk_bit(g_bb, 1'h1);
    axi_wr(REG_CTRL, 32'h00000001, r);
    wait_on(S1, 1'h0, 10, n);
    $display("gate test done");
    axi_wr(REG_MASK, 32'h0000001F, r);
    cyc(2);
    chk_bit(irq, 1'h1);
    axi_wr(REG_MASK, 32'h00000000, r);
    cyc(2);
    chk_bit(irq, 1'h0);
    axi_wr(REG_MASK, 32'h0000001F, r);
    axi_rd(REG_IRQ, d, r);
    chk_word(d, 32'h00000017);
    cyc(2);
    chk_bit(irq, 1'h0);
    axi_rd(REG_IRQ, d, r);
    chk_word(d, 32'h0);
    axi_rd(8'h14, d, r);
    chk_word({30'h0, r}, 32'h2);
    axi_wr(8'h18, 32'h1, r);
    chk_word({30'h0, r}, 32'h2);
    $display("register test done");
    ov <= 1'h1;
    cyc(OV_FILT_CYC - 3);
    chk_bit(fault_flag_output, 1'h1);
    wait_on(FF, 1'h0, 8, n);
    chk_bit(pre_en, 1'h1);
    chk_bit(mrst, 1'h0);
    ov <= 1'h0;
    wait_on(FF, 1'h1, 8, n);
    $display("fault flag test done");
    le <= 1'h0;
    cyc(DEGLITCH_CYC - 4);
    chk_bit(hrst, 1'h1);
    chk_bit(gen_en, 1'h1);
    wait_on(GEN, 1'h0, 10, n);
    chk_bit(uc_en, 1'h1);
    wait_on(UC, 1'h0, 40, n);
    chk_bit(pre_en, 1'h1);
    cyc(2);
    chk_bit(hrst, 1'h0);
    wait_on(PRE, 1'h0, 60, n);
    chk_bit(g_bb, 1'h0);
    $display("shutdown test done");
    wrap_up();
  end
endmodule
`default_nettype wire
